// [rtl/arc_pkg.sv]
`default_nettype none

package arc_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CH = 8;
	localparam int NUM_CFG = 24;
	localparam int CTRL_BITS = 8;
	localparam int WORD_BITS = 24;
	localparam int CRC_BITS = 16;
	localparam int CRC_WIDE_BITS = 32;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [4:0] ADDR_FIRST = 5'h00;
	localparam logic [4:0] ADDR_CH_LAST = 5'h07;
	localparam logic [4:0] ADDR_CFG_FIRST = 5'h08;
	localparam logic [4:0] ADDR_CRC_FIRST = 5'h09;
	localparam logic [4:0] ADDR_STATUS = 5'h0c;
	localparam logic [4:0] ADDR_LOCK = 5'h1f;
	localparam logic [7:0] LOCK_PASSWORD = 8'ha5;
	localparam logic [7:0] FLAGS_ALL_ONES = 8'hff;
	localparam logic [15:0] CRC_POLY = 16'h8005;

	// Reset values
	localparam logic [23:0] CFG_RESET = 24'h00_0000;
	localparam logic [23:0] STATUS_RESET = 24'h00_00b8;
	localparam logic [23:0] LOCK_RESET = 24'ha5_0000;

	// Fields of the communication status/config word
	localparam int ST_CRC_EN = 0;
	localparam int ST_WIDTH_CRC = 1;
	localparam int ST_EN_INT = 2;
	localparam int ST_DR_HIZ = 3;
	localparam int ST_CHANNEL_READY_LINK = 4;
	localparam int ST_WRITE = 5;
	localparam int ST_READ = 6;
	localparam int ST_FLAGS = 8;
	// Key field of the last register
	localparam int LOCK_POS = 16;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MOD_PERIOD_NS = 20;
	localparam int CFG_CRC_MOD_PERIODS = 25;
	localparam int CFG_CRC_CYCLES = CFG_CRC_MOD_PERIODS * MOD_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] CRC_PERIOD_LAST = 6'(CFG_CRC_CYCLES - 1);
	localparam logic [1:0] DR_PULSE_CNT = 2'(MOD_PERIOD_NS / 2 / CLK_PERIOD_NS);

	// Bit counter end values
	localparam logic [4:0] CTRL_LAST = 5'(CTRL_BITS - 1);
	localparam logic [4:0] WORD_LAST = 5'(WORD_BITS - 1);
	localparam logic [4:0] CRC_LAST = 5'(CRC_BITS - 1);
	localparam logic [4:0] CRC_WIDE_LAST = 5'(CRC_WIDE_BITS - 1);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {RD_STATIC, RD_GROUPS, RD_TYPES, RD_FULL} arc_read_mode_t;
	typedef enum logic [1:0] {PH_CTRL, PH_READ, PH_WRITE, PH_CRC} arc_phase_t;

	// Converter results with their ready pulses
	typedef struct packed {
		logic [NUM_CH-1:0] ready;
		logic [NUM_CH-1:0][WORD_BITS-1:0] data;
	} arc_chan_t;

	// Levels and toggles crossing into the modulator domain
	typedef struct packed {
		logic locked;
		logic drLink;
		logic enInt;
		logic drHiz;
		logic [NUM_CH-1:0] readTog;
	} arc_ctl_t;

	// Modulator-domain state
	typedef struct packed {
		logic [NUM_CH-1:0][WORD_BITS-1:0] stage1;
		logic [NUM_CH-1:0] readyN;
		logic [NUM_CH-1:0] readTogPrev;
		logic [1:0] drCnt;
		logic drOut;
		logic drOe;
		logic [5:0] periodCnt;
		logic busy;
		logic [4:0] crcIdx;
		logic [15:0] crcAcc;
		logic [15:0] config_checksum_value;
		logic [15:0] refSum;
		logic refValid;
		logic fault;
	} arc_mod_state_t;

	// Serial frame state, cleared between frames
	typedef struct packed {
		arc_phase_t phase;
		logic [4:0] bitCnt;
		logic [23:0] shift;
		logic [4:0] addr;
		logic [15:0] crc;
		logic sdo;
		logic sdoOe;
	} arc_frame_state_t;

	// Register storage, addresses 0x08..0x1F
	typedef struct packed {
		logic [NUM_CFG-1:0][WORD_BITS-1:0] cfg;
		logic [NUM_CH-1:0] readTog;
	} arc_cfg_state_t;

	localparam arc_cfg_state_t CFG_STATE_RESET = '{
		cfg: {LOCK_RESET, {18{CFG_RESET}}, STATUS_RESET, {4{CFG_RESET}}},
		readTog: 8'h00
	};

	// ----------------------------------------
	// Checksum arithmetic
	// ----------------------------------------
	// One message bit, MSB first, no reflection
	function automatic logic [15:0] arc_crc_bit(input logic [15:0] crc, input logic b);
		return {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
	endfunction

	// A whole register word, MSB first
	function automatic logic [15:0] arc_crc_word(input logic [15:0] crc, input logic [23:0] w);
		logic [15:0] c;
		c = crc;
		for (int i = WORD_BITS - 1; i >= 0; i--) begin
			c = arc_crc_bit(c, w[i]);
		end
		return c;
	endfunction

endpackage

`default_nettype wire

// [rtl/arc_sync2.sv]
`default_nettype none

module arc_sync2 #(
	parameter int W = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bits from the other domain
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} arc_sync_state_t;

	arc_sync_state_t sReg;
	arc_sync_state_t sNext;

	// First stage feeds only the second stage
	always_comb begin
		sNext.meta = din;
		sNext.held = sReg.meta;
		if (rst) begin
			sNext = '0;
		end
	end

	always_ff @(posedge clk) begin
		sReg <= sNext;
	end

	assign dout = sReg.held;

endmodule // arc_sync2

`default_nettype wire

// [rtl/arc_readout_crc_lock.sv]
`default_nettype none

module arc_readout_crc_lock
	import arc_pkg::*;
(
	// System (modulator) clock and reset
	input wire logic clk,
	input wire logic rst,
	// Converter results
	input wire arc_chan_t chan,
	// Serial link
	input wire logic sck,
	input wire logic csN,
	input wire logic sdi,
	output logic sdo,
	output logic sdoOe,
	// Sample-ready pin
	output logic drPinOut,
	output logic drPinOe
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	arc_mod_state_t mReg;       // Modulator domain
	arc_mod_state_t mNext;
	arc_frame_state_t fReg;     // Link domain, per frame
	arc_frame_state_t fNext;
	arc_cfg_state_t cReg;       // Link domain, register storage
	arc_cfg_state_t cNext;

	// ----------------------------------------
	// Crossings
	// ----------------------------------------
	arc_ctl_t ctlRaw;           // Link-domain levels and toggles
	arc_ctl_t ctlS;             // Same, synchronised to clk
	logic [NUM_CH-1:0] flagsS;  // Ready flags, synchronised to sck
	logic frameClr;             // Clears frame state between frames
	logic unlocked;             // Key equals the password
	logic [23:0] statusWord;    // Raw status/config storage

	assign statusWord = cReg.cfg[5'(ADDR_STATUS - ADDR_CFG_FIRST)];
	assign unlocked = cReg.cfg[5'(ADDR_LOCK - ADDR_CFG_FIRST)][LOCK_POS +: 8]
		== LOCK_PASSWORD;

	assign ctlRaw.locked = !unlocked;
	assign ctlRaw.drLink = statusWord[ST_CHANNEL_READY_LINK];
	assign ctlRaw.enInt = statusWord[ST_EN_INT];
	assign ctlRaw.drHiz = statusWord[ST_DR_HIZ];
	assign ctlRaw.readTog = cReg.readTog;

	// Control levels and read-start toggles into the modulator domain
	arc_sync2 #(.W($bits(arc_ctl_t))) u_sync_ctl (
		.clk(clk),
		.rst(rst),
		.din(ctlRaw),
		.dout(ctlS)
	);

	// Ready flags into the link domain; only ever shown to software
	arc_sync2 #(.W(NUM_CH)) u_sync_flags (
		.clk(sck),
		.rst(1'b0),
		.din(mReg.readyN),
		.dout(flagsS)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	// Storage word with the flag and checksum fields replaced
	function automatic logic [23:0] cfgWord(input logic [4:0] a, input logic [7:0] fl,
		input logic [15:0] cs);
		logic [23:0] w;
		w = cReg.cfg[5'(a - ADDR_CFG_FIRST)];
		if (a == ADDR_STATUS) begin
			w[ST_FLAGS +: NUM_CH] = fl;
		end
		if (a == ADDR_LOCK) begin
			w[CRC_BITS-1:0] = cs;
		end
		return w;
	endfunction

	// First and last address of the read set holding address a
	function automatic logic [9:0] setBounds(input logic [4:0] a, input arc_read_mode_t md);
		logic [4:0] lo;
		logic [4:0] hi;
		logic isCh;
		isCh = a <= ADDR_CH_LAST;
		lo = a;
		hi = a;
		unique case (md)
			RD_STATIC: begin
				lo = a;
				hi = a;
			end
			RD_GROUPS: begin
				// Channel pairs; configuration as one group
				lo = isCh ? {a[4:1], 1'b0} : ADDR_CFG_FIRST;
				hi = isCh ? {a[4:1], 1'b1} : ADDR_LOCK;
			end
			RD_TYPES: begin
				lo = isCh ? ADDR_FIRST : ADDR_CFG_FIRST;
				hi = isCh ? ADDR_CH_LAST : ADDR_LOCK;
			end
			RD_FULL: begin
				lo = ADDR_FIRST;
				hi = ADDR_LOCK;
			end
		endcase
		return {lo, hi};
	endfunction

	// ----------------------------------------
	// Modulator domain: latch, flags, pin, checksum
	// ----------------------------------------
	// Stage one and the ready flags update in the same edge as the pin pulse
	always_comb begin
		logic [15:0] acc;
		logic anyReady;
		mNext = mReg;
		acc = arc_crc_word(mReg.crcAcc,
			cfgWord(mReg.crcIdx, FLAGS_ALL_ONES, 16'h0000));
		anyReady = |chan.ready;

		// A started read of a channel marks its flag consumed
		mNext.readTogPrev = ctlS.readTog;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (ctlS.readTog[ch] != mReg.readTogPrev[ch]) begin
				mNext.readyN[ch] = 1'b1;
			end
			// New data beats a read in the same cycle
			if (chan.ready[ch] || (ctlS.drLink && anyReady)) begin
				mNext.stage1[ch] = chan.data[ch];
				mNext.readyN[ch] = 1'b0;
			end
		end

		// Active-low pulse of half a modulator period
		if (anyReady) begin
			mNext.drCnt = DR_PULSE_CNT;
		end else if (mReg.drCnt != 2'h0) begin
			mNext.drCnt = mReg.drCnt - 2'h1;
		end

		// Configuration checksum engine, one word per cycle
		if (!ctlS.locked) begin
			// Unlocked: field reads zero, reference and fault dropped
			mNext.config_checksum_value = 16'h0000;
			mNext.refValid = 1'b0;
			mNext.fault = 1'b0;
			mNext.periodCnt = 6'h00;
			mNext.busy = 1'b0;
		end else begin
			// Restart every 25 modulator periods
			if (mReg.periodCnt == CRC_PERIOD_LAST) begin
				mNext.periodCnt = 6'h00;
			end else begin
				mNext.periodCnt = mReg.periodCnt + 6'h01;
			end
			if (mReg.periodCnt == 6'h00) begin
				mNext.busy = 1'b1;
				mNext.crcIdx = ADDR_CRC_FIRST;
				mNext.crcAcc = 16'h0000;
			end
			if (mReg.busy) begin
				mNext.crcAcc = acc;
				mNext.crcIdx = mReg.crcIdx + 5'h01;
				// Last word done: publish and compare
				if (mReg.crcIdx == ADDR_LOCK) begin
					mNext.busy = 1'b0;
					mNext.config_checksum_value = acc;
					if (!mReg.refValid) begin
						mNext.refSum = acc;
						mNext.refValid = 1'b1;
					end else if (acc != mReg.refSum && ctlS.enInt) begin
						mNext.fault = 1'b1;
					end
				end
			end
		end

		// Pin is low for a pulse or while the fault stands
		mNext.drOut = !((mNext.drCnt != 2'h0) || mNext.fault);
		// Without drive-high mode the pin floats when not low
		mNext.drOe = ctlS.drHiz || !mNext.drOut;

		// Reset leaves the map unlocked and no fault raised
		if (rst) begin
			mNext = '0;
			mNext.readyN = '1;
			mNext.drOut = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		mReg <= mNext;
	end

	// ----------------------------------------
	// Link domain: command, read, write, checksum
	// ----------------------------------------
	// Stage one is read across domains unsynchronised; the host must wait
	// the update delay after the pin falls, or poll the flags, so the word
	// is still while it is captured.
	always_comb begin
		logic [23:0] w;
		logic [9:0] bnd;
		logic [4:0] first;
		logic [4:0] last;
		logic load;
		logic [4:0] loadAddr;
		logic [23:0] wdata;
		fNext = fReg;
		cNext = cReg;
		w = 24'h00_0000;
		bnd = setBounds(fReg.addr, arc_read_mode_t'(statusWord[ST_READ +: 2]));
		first = bnd[9:5];
		last = bnd[4:0];
		load = 1'b0;
		loadAddr = fReg.addr;
		wdata = {fReg.shift[22:0], sdi};

		unique case (fReg.phase)
			// Control byte: address in bits 5..1, read when bit 0 is set
			PH_CTRL: begin
				fNext.shift = wdata;
				fNext.bitCnt = fReg.bitCnt + 5'h01;
				if (fReg.bitCnt == CTRL_LAST) begin
					fNext.addr = fReg.shift[4:0];
					fNext.bitCnt = 5'h00;
					if (sdi) begin
						load = 1'b1;
						loadAddr = fReg.shift[4:0];
					end else begin
						fNext.phase = PH_WRITE;
					end
				end
			end
			// Shift a word out; the next word starts only after the last bit
			PH_READ: begin
				if (fReg.bitCnt == WORD_LAST) begin
					if (fReg.addr == last && statusWord[ST_CRC_EN]) begin
						// End of set: checksum before wrapping
						fNext.phase = PH_CRC;
						fNext.bitCnt = 5'h00;
						fNext.sdo = fReg.crc[15];
						fNext.crc = {fReg.crc[14:0], 1'b0};
					end else begin
						load = 1'b1;
						loadAddr = (fReg.addr == last) ? first : fReg.addr + 5'h01;
					end
				end else begin
					fNext.bitCnt = fReg.bitCnt + 5'h01;
					fNext.sdo = fReg.shift[23];
					fNext.shift = {fReg.shift[22:0], 1'b0};
					fNext.crc = arc_crc_bit(fReg.crc, fReg.shift[23]);
				end
			end
			// Checksum out; shifting leaves zeros for the wide format
			PH_CRC: begin
				if (fReg.bitCnt == (statusWord[ST_WIDTH_CRC] ? CRC_WIDE_LAST
					: CRC_LAST)) begin
					load = 1'b1;
					loadAddr = first;
				end else begin
					fNext.bitCnt = fReg.bitCnt + 5'h01;
					fNext.sdo = fReg.crc[15];
					fNext.crc = {fReg.crc[14:0], 1'b0};
				end
			end
			// Shift a word in, commit it on the last bit
			PH_WRITE: begin
				fNext.shift = wdata;
				fNext.bitCnt = fReg.bitCnt + 5'h01;
				if (fReg.bitCnt == WORD_LAST) begin
					fNext.bitCnt = 5'h00;
					// Result addresses: no effect, pointer held
					if (fReg.addr > ADDR_CH_LAST) begin
						if (fReg.addr == ADDR_LOCK) begin
							// Only the key is writable here
							cNext.cfg[5'(ADDR_LOCK - ADDR_CFG_FIRST)] =
								{wdata[LOCK_POS +: 8], 16'h0000};
						end else if (unlocked) begin
							cNext.cfg[5'(fReg.addr - ADDR_CFG_FIRST)] = wdata;
						end
						if (statusWord[ST_WRITE]) begin
							fNext.addr = (fReg.addr == ADDR_LOCK) ? ADDR_CFG_FIRST
								: fReg.addr + 5'h01;
						end
					end
				end
			end
		endcase

		// Start of a word: capture it and put its MSB out
		if (load) begin
			if (loadAddr <= ADDR_CH_LAST) begin
				// Second stage: result frozen for the whole read
				w = mReg.stage1[loadAddr[2:0]];
				cNext.readTog[loadAddr[2:0]] = !cReg.readTog[loadAddr[2:0]];
			end else begin
				w = cfgWord(loadAddr, flagsS, mReg.config_checksum_value);
			end
			fNext.phase = PH_READ;
			fNext.addr = loadAddr;
			fNext.bitCnt = 5'h00;
			fNext.sdo = w[23];
			fNext.shift = {w[22:0], 1'b0};
			fNext.crc = arc_crc_bit(fReg.crc, w[23]);
		end

		fNext.sdoOe = (fNext.phase == PH_READ) || (fNext.phase == PH_CRC);
	end

	// Frame state is cleared whenever the select is high
	assign frameClr = csN || rst;

	always_ff @(posedge sck or posedge frameClr) begin
		if (frameClr) begin
			fReg <= '0;
		end else begin
			fReg <= fNext;
		end
	end

	// Register storage survives frames; reset unlocks the map
	always_ff @(posedge sck or posedge rst) begin
		if (rst) begin
			cReg <= CFG_STATE_RESET;
		end else begin
			cReg <= cNext;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------
	assign sdo = fReg.sdo;
	assign sdoOe = fReg.sdoOe;
	assign drPinOut = mReg.drOut;
	assign drPinOe = mReg.drOe;

endmodule // arc_readout_crc_lock

`default_nettype wire

// [testbench/arc_readout_crc_lock_properties.sv]
`default_nettype none

module arc_readout_checker
	import arc_pkg::*;
(
	// Modulator domain
	input wire logic clk,
	input wire logic rst,
	input wire arc_chan_t chan,
	// Serial link
	input wire logic sck,
	input wire logic csN,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdoOe,
	// Sample-ready pin
	input wire logic drPinOut,
	input wire logic drPinOe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [8:0] edgeCnt; // Rising link edges this frame, saturating
	logic [7:0] ctlByte; // Control byte as shifted in

	// Frame tracker, cleared by chip select like the frame state
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			edgeCnt <= '0;
			ctlByte <= '0;
		end else begin
			edgeCnt <= (edgeCnt == 9'h1ff) ? edgeCnt : edgeCnt + 9'h001;
			if (edgeCnt < 9'h008) begin
				ctlByte <= {ctlByte[6:0], sdi};
			end
		end
	end

	// ----------------------------------------
	// Sample-ready pin
	// ----------------------------------------
	ready_drop_a: assert property (@(posedge clk) disable iff (rst)
		|chan.ready |=> !drPinOut) else $error("pin missed ready");
	pulse_end_a: assert property (@(posedge clk) disable iff (rst)
		$fell(drPinOut) && $past(|chan.ready) |=> drPinOut) else $error("pulse too long");
	low_driven_a: assert property (@(posedge clk) disable iff (rst)
		!drPinOut |-> drPinOe) else $error("low pin not driven");
	reset_idle_a: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> drPinOut && !sdoOe) else $error("not idle after reset");

	// ----------------------------------------
	// Serial output enable
	// ----------------------------------------
	quiet_frame_a: assert property (@(posedge clk) disable iff (rst)
		csN |-> !sdoOe) else $error("sdo driven outside frame");
	ctl_silent_a: assert property (@(posedge sck) disable iff (rst || csN)
		edgeCnt < 9'h008 |-> !sdoOe) else $error("sdo driven in control byte");
	read_drive_a: assert property (@(posedge sck) disable iff (rst || csN)
		edgeCnt >= 9'h008 && ctlByte[0] |-> sdoOe) else $error("read not driven");
	write_quiet_a: assert property (@(posedge sck) disable iff (rst || csN)
		edgeCnt >= 9'h008 && !ctlByte[0] |-> !sdoOe) else $error("write drives sdo");

endmodule // arc_readout_checker

bind arc_readout_crc_lock arc_readout_checker u_checker (.clk(clk), .rst(rst), .chan(chan),
	.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .drPinOut(drPinOut),
	.drPinOe(drPinOe));

`default_nettype wire

// [testbench/arc_host_model.sv]
`default_nettype none

module arc_host_model #(
	parameter int UPDATE_NS = 40 // Output update delay, plain default
) (
	// Serial link
	output logic sck,
	output logic csN,
	output logic sdi,
	input wire logic sdo,
	// Sample-ready pin level
	input wire logic drPin
);
	timeunit 1ns;
	timeprecision 100ps;

	// Link clock stands still between frames
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end

	// One frame: tx bits n-1..0 out, sdo sampled at each falling edge
	task automatic xfer(input int n, input logic [263:0] tx, output logic [263:0] rx);
		rx = '0;
		csN = 1'b0;
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = tx[i]; // Exactly n bits, whole words or not
			#3 sck = 1'b1;
			#3 sck = 1'b0;
			rx = {rx[262:0], sdo};
		end
		#3 csN = 1'b1;
		sdi = ~sdi; // A released line shows no stale level
		// Select stays high for a bit time, so back-to-back frames still clear
		#6;
	endtask

	// Interrupt-driven host reads only after the update delay
	task automatic waitReady();
		@(negedge drPin);
		#UPDATE_NS;
	endtask

	// Checksum step, MSB first, zero seed, no inversion
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
		return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h8005 : 16'h0000);
	endfunction

	// Remainder over sequence plus checksum; zero when the checksum matches
	function automatic logic [15:0] remainder(input int n, input logic [263:0] v);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = n - 1; i >= 0; i--) c = crcStep(c, v[i]);
		return c;
	endfunction

endmodule // arc_host_model

`default_nettype wire

// [testbench/tb_arc_readout_crc_lock.sv]
`default_nettype none
`define CHK(nm, e, g) checks++; if ((g) !== (e)) begin errCount++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end

module tb_arc_readout_crc_lock
	import arc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0; // 100 MHz system clock
	logic rst;
	arc_chan_t chan;
	logic sck, csN, sdi, sdo, sdoOe, drPinOut, drPinOe;
	logic pinLevel; // Pin as the host sees it
	int errCount = 0;
	int checks = 0;
	logic [263:0] rx; // Last frame as sampled
	logic [23:0] w;

	always #5 clk = ~clk;

	// Pull-up holds a floating pin high
	assign pinLevel = drPinOe ? drPinOut : 1'b1;

	arc_readout_crc_lock u_dut (.clk(clk), .rst(rst), .chan(chan), .sck(sck), .csN(csN),
		.sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .drPinOut(drPinOut), .drPinOe(drPinOe));
	// Undriven data line floats high at the host, so a missing enable shows
	arc_host_model u_host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdoOe ? sdo : 1'b1),
		.drPin(pinLevel));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic rdReg(input logic [4:0] a, output logic [23:0] v);
		u_host.xfer(31, 264'({2'b00, a, 1'b1, 23'h00_0000}), rx);
		v = rx[23:0];
	endtask

	task automatic wrReg(input logic [4:0] a, input logic [23:0] v);
		u_host.xfer(32, 264'({2'b00, a, 1'b0, v}), rx);
	endtask

	// One ready pulse on channel 0 only; the link loads all eight
	task automatic pulse(input logic [23:0] base);
		@(negedge clk);
		for (int i = 0; i < NUM_CH; i++) chan.data[i] = base + 24'(i);
		chan.ready = 8'h01;
		@(negedge clk);
		chan.ready = 8'h00;
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", errCount, checks);
		if (errCount == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic resetValues();
		`CHK("pin idle", 2'b11, {drPinOut, drPinOe})
		rdReg(ADDR_STATUS, w);
		`CHK("status", 16'hffb8, w[15:0])
		rdReg(ADDR_LOCK, w);
		`CHK("lock word", LOCK_RESET, w)
	endtask

	// Whole channel set; new results land while channel 1 is shifting
	task automatic readAll(input logic [1:0] mode);
		int n;
		logic [23:0] e;
		n = (mode == 2'b00) ? 24 : 16 * int'(mode);
		wrReg(ADDR_STATUS, {16'h0000, 6'b10_1110, mode[1], mode != 2'b00});
		fork
			u_host.waitReady();
			pulse(24'h10_0000);
		join
		fork
			u_host.xfer(199 + n, 264'({2'b00, ADDR_FIRST, 1'b1}) << (191 + n), rx);
			begin
				#250;
				pulse(24'h20_0000);
			end
		join
		for (int i = 0; i < NUM_CH; i++) begin
			e = ((i < 2) ? 24'h10_0000 : 24'h20_0000) + 24'(i);
			`CHK("channel word", e, rx[n + 24 * (7 - i) +: 24])
		end
		if (mode == 2'b00) begin
			`CHK("wrapped word", 24'h20_0000, rx[23:0])
		end else begin
			`CHK("remainder", 16'h0000, u_host.remainder(208, rx >> (n - 16)))
			`CHK("checksum pad", 16'h0000, rx[15:0] & {16{mode[1]}})
		end
	endtask

	// Result words refuse writes
	task automatic resultWrite();
		u_host.xfer(56, {208'd0, 2'b00, ADDR_FIRST, 1'b0, 48'h0000_1234_5678}, rx);
		rdReg(ADDR_FIRST, w);
		`CHK("result kept", 24'h20_0000, w)
	endtask

	// Polled read: wait for the flags to clear, read one channel, see its flag return
	task automatic pollRead();
		pulse(24'h30_0000);
		w = 24'hff_ffff;
		for (int k = 0; k < 4 && w[15:8] != 8'h00; k++) rdReg(ADDR_STATUS, w);
		`CHK("flags cleared", 8'h00, w[15:8])
		rdReg(5'h03, w);
		`CHK("polled word", 24'h30_0003, w)
		rdReg(ADDR_STATUS, w);
		`CHK("flag consumed", 8'h08, w[15:8])
	endtask

	// Lock, reference checksum, locked write, fault, unlock
	task automatic lockAndFault();
		logic [15:0] c;
		wrReg(ADDR_CFG_FIRST, 24'h00_0c3a);
		wrReg(ADDR_STATUS, 24'h00_00bc); // Interrupt on, no link checksum
		wrReg(ADDR_LOCK, 24'h00_0000); // Lock with zeros
		c = 16'h0000;
		for (int a = 9; a < 32; a++) begin
			w = (a == 12) ? 24'h00_ffbc : 24'h00_0000; // Flags as ones
			for (int b = 23; b >= 0; b--) c = u_host.crcStep(c, w[b]);
		end
		repeat (120) @(negedge clk);
		rdReg(ADDR_LOCK, w);
		`CHK("config checksum", {8'h00, c}, w)
		wrReg(ADDR_CFG_FIRST, 24'h00_0001);
		rdReg(ADDR_CFG_FIRST, w);
		`CHK("locked write", 24'h00_0c3a, w)
		`CHK("no fault", 1'b1, pinLevel)
		wrReg(ADDR_LOCK, 24'h01_0000);
		repeat (120) @(negedge clk);
		`CHK("fault pin", 1'b0, pinLevel)
		repeat (60) @(negedge clk);
		`CHK("fault held", 1'b0, pinLevel)
		wrReg(ADDR_LOCK, LOCK_RESET);
		repeat (10) @(negedge clk);
		`CHK("unlock clears", 1'b1, pinLevel)
		rdReg(ADDR_LOCK, w);
		`CHK("unlocked word", LOCK_RESET, w)
		wrReg(ADDR_CFG_FIRST, 24'h00_0001);
		rdReg(ADDR_CFG_FIRST, w);
		`CHK("open write", 24'h00_0001, w)
	endtask

	// Watchdog, well past the expected run of some 12 us
	initial begin
		#100000;
		errCount++;
		summarize();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		chan = '0;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		resetValues();
		for (int m = 0; m < 3; m++) readAll(2'(m));
		resultWrite();
		pollRead();
		lockAndFault();
		summarize();
	end

endmodule // tb_arc_readout_crc_lock

`default_nettype wire
